//--- hw/cgb_fifo.sv
`timescale 1ns/1ps

module cgb_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input logic clock,
  input logic rst_n,
  input logic clk_en,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import cgb_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic ready_reg;
  logic valid_reg;
  logic [WIDTH-1:0] data_reg;
  logic push;
  logic pop;

  // Registered full flag: a push is only taken while a slot is known free
  assign push = in_valid && ready_reg;
  assign pop = (count_reg != '0) && (!valid_reg || out_ready);
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = ready_reg;
  assign out_valid = valid_reg;
  assign out_data = data_reg;

  always_ff @(posedge clock)
  begin
    if (clk_en && push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
      data_reg <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        data_reg <= mem_reg[rd_ptr_reg];
      end
      count_reg <= count_next;
      ready_reg <= (count_next < (AW+1)'(DEPTH));
      if (pop)
        valid_reg <= 1'b1;
      else if (out_ready)
        valid_reg <= 1'b0;
    end
  end

endmodule : cgb_fifo

//--- hw/cgb_gain_black.sv
// Operation
// - Two-bit coarse gain code selects 1x..8x
// - Gain code plus ten bits give thirteen
// - Divide by gain via right shift
// - Keep three extra low bits
// - Fixed gain forces one code, shifts output
// - Register selects full-scale input level
// - Loop holds black at code 64
// - Loop runs only during clamp strobe
// - Short clamp: one update per line
// - Long clamp: update every n+10 cycles
// - Integrator gain K times n
// - Range bit clear halves loop gain
// - Nine accumulator MSBs readable, write clears LSBs
// - Accumulator starts at mid-range
// - Loop can be disabled; level settable
// - Black is 8 (10-bit), 64 (13-bit)
// - Add calibration offsets at 2x, 4x and 8x gain
`timescale 1ns/1ps
`include "cgb_defines.svh"

module cgb_gain_black (
  input logic clock,
  input logic rst_n,
  input logic clk_en,
  input cgb_pkg::cgb_gain_t gain_code,
  input logic [9:0] conv_data,
  input logic conv_valid,
  output logic conv_ready,
  input logic clamp_pin,
  input logic reg_wr_en,
  input logic reg_rd_en,
  input logic [6:0] reg_addr,
  input logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output cgb_pkg::cgb_pix_t pix_out,
  output logic pix_out_valid,
  input logic pix_out_ready,
  output logic [8:0] black_level,
  output logic [2:0] full_scale_code,
  output logic cal_start
);
  import cgb_pkg::*;

  // ***************************************************
  // Register file
  // ***************************************************
  logic [7:0] full_scale_reg;
  logic [7:0] loop_ctrl_reg;
  logic [7:0] pix_count_reg;
  logic [7:0] offset_a_reg;
  logic [7:0] offset_b_reg;
  logic [7:0] offset_c_reg;
  logic [7:0] forced_gain_reg;
  logic black_lo_reg;
  logic [7:0] reg_rdata_reg;
  logic cal_start_reg;
  logic [15:0] acc_reg;
  logic [15:0] acc_next;
  cgb_bl_state_t bl_state_reg;
  cgb_bl_state_t bl_state_next;

  // ***************************************************
  // Register decode
  // ***************************************************

  logic wr_full_scale;
  logic wr_loop_ctrl;
  logic wr_black_hi;
  logic wr_black_lo;
  logic wr_pix_count;
  logic wr_offset_a;
  logic wr_offset_b;
  logic wr_offset_c;
  logic wr_forced_gain;
  logic [7:0] rd_mux;

  assign wr_full_scale = reg_wr_en && reg_addr == `CGB_ADDR_FULL_SCALE;
  assign wr_loop_ctrl = reg_wr_en && reg_addr == `CGB_ADDR_LOOP_CTRL;
  assign wr_black_hi = reg_wr_en && reg_addr == `CGB_ADDR_BLACK_HI;
  assign wr_black_lo = reg_wr_en && reg_addr == `CGB_ADDR_BLACK_LO;
  assign wr_pix_count = reg_wr_en && reg_addr == `CGB_ADDR_PIX_COUNT;
  assign wr_offset_a = reg_wr_en && reg_addr == `CGB_ADDR_OFFSET_A;
  assign wr_offset_b = reg_wr_en && reg_addr == `CGB_ADDR_OFFSET_B;
  assign wr_offset_c = reg_wr_en && reg_addr == `CGB_ADDR_OFFSET_C;
  assign wr_forced_gain = reg_wr_en && reg_addr == `CGB_ADDR_FORCED_GAIN;

  // Unmapped offsets read as zero
  assign rd_mux =
    (reg_addr == `CGB_ADDR_FULL_SCALE) ? full_scale_reg :
    (reg_addr == `CGB_ADDR_LOOP_CTRL) ? loop_ctrl_reg :
    (reg_addr == `CGB_ADDR_BLACK_HI) ? acc_reg[15:8] :
    (reg_addr == `CGB_ADDR_BLACK_LO) ?
      {6'h00, bl_state_reg == CGB_BL_RUN, acc_reg[7]} :
    (reg_addr == `CGB_ADDR_PIX_COUNT) ? pix_count_reg :
    (reg_addr == `CGB_ADDR_OFFSET_A) ? offset_a_reg :
    (reg_addr == `CGB_ADDR_OFFSET_B) ? offset_b_reg :
    (reg_addr == `CGB_ADDR_OFFSET_C) ? offset_c_reg :
    (reg_addr == `CGB_ADDR_FORCED_GAIN) ? forced_gain_reg : 8'h00;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_scale_reg <= `CGB_RST_FULL_SCALE;
      loop_ctrl_reg <= `CGB_RST_LOOP_CTRL;
      pix_count_reg <= `CGB_RST_PIX_COUNT;
      offset_a_reg <= `CGB_RST_OFFSET;
      offset_b_reg <= `CGB_RST_OFFSET;
      offset_c_reg <= `CGB_RST_OFFSET;
      forced_gain_reg <= `CGB_RST_FORCED_GAIN;
      black_lo_reg <= 1'b0;
      reg_rdata_reg <= 8'h00;
      cal_start_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_full_scale)
        full_scale_reg <= reg_wdata;
      if (wr_loop_ctrl)
        loop_ctrl_reg <= reg_wdata;
      if (wr_pix_count)
        pix_count_reg <= reg_wdata;
      if (wr_offset_a)
        offset_a_reg <= reg_wdata;
      if (wr_offset_b)
        offset_b_reg <= reg_wdata;
      if (wr_offset_c)
        offset_c_reg <= reg_wdata;
      if (wr_forced_gain)
        forced_gain_reg <= reg_wdata;
      if (wr_black_lo)
        black_lo_reg <= reg_wdata[`CGB_BL_LO_ACC_BIT];
      if (reg_rd_en)
        reg_rdata_reg <= rd_mux;
      // One-cycle kick to the calibration engine
      cal_start_reg <= wr_full_scale && reg_wdata[`CGB_FS_CAL_BIT];
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign cal_start = cal_start_reg;
  assign full_scale_code = full_scale_reg[`CGB_FS_CODE_MSB:`CGB_FS_CODE_LSB];

  // ***************************************************
  // Gain adjust
  // ***************************************************
  logic force_en;
  cgb_gain_t eff_gain;
  logic [12:0] shifted;
  logic [7:0] offset_sel;
  logic signed [14:0] sum_adj;
  cgb_pix_t adj_pix;

  assign force_en = forced_gain_reg[`CGB_FG_EN_BIT];
  assign eff_gain = force_en ?
    cgb_gain_t'(forced_gain_reg[`CGB_FG_CODE_MSB:0]) : gain_code;
  // Three fraction bits appended, then one place per doubling
  assign shifted = {conv_data, 3'b000} >> eff_gain;
  assign offset_sel =
    (eff_gain == CGB_GAIN_2X) ? offset_a_reg :
    (eff_gain == CGB_GAIN_4X) ? offset_b_reg :
    (eff_gain == CGB_GAIN_8X) ? offset_c_reg : 8'h00;
  assign sum_adj = $signed({2'b00, shifted}) +
    $signed({{7{offset_sel[7]}}, offset_sel});
  // Clip so a negative or oversized correction cannot wrap
  assign adj_pix = (sum_adj < 0) ? 13'h0000 :
    (sum_adj > $signed({2'b00, `CGB_PIX_MAX})) ? `CGB_PIX_MAX :
    sum_adj[12:0];

  // ***************************************************
  // Pixel buffer
  // ***************************************************

  logic fifo_ready;
  logic accept;

  assign accept = conv_valid && fifo_ready;
  // Registered full flag keeps the source free of a comb path
  assign conv_ready = fifo_ready;

  cgb_fifo #(
    .WIDTH(13),
    .DEPTH(`CGB_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(conv_valid),
    .in_ready(fifo_ready),
    .in_data(adj_pix),
    .out_valid(pix_out_valid),
    .out_ready(pix_out_ready),
    .out_data(pix_out)
  );

  // ***************************************************
  // Clamp synchroniser
  // ***************************************************
  logic clamp_meta_reg;
  logic clamp_sync_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clamp_meta_reg <= 1'b0;
      clamp_sync_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      clamp_meta_reg <= clamp_pin;
      clamp_sync_reg <= clamp_meta_reg;
    end
  end

  // ***************************************************
  // Black level loop
  // ***************************************************
  logic [5:0] n_pix;
  logic [6:0] period_last;
  logic [6:0] per_cnt_reg;
  logic [5:0] pix_cnt_reg;
  logic [19:0] sum_reg;
  logic take_pix;
  logic period_end;
  logic do_update;
  logic loop_off;
  logic [1:0] blk_gain;
  logic [12:0] target_prod;
  logic signed [20:0] target_sum;
  logic signed [20:0] err;
  logic signed [23:0] err_scaled;
  logic signed [23:0] delta;
  logic signed [17:0] acc_sum;

  assign n_pix = pix_count_reg[`CGB_PC_N_MSB:0];
  // Counter runs 0..n+9, so one period lasts n+10 cycles
  assign period_last = 7'(n_pix) + `CGB_PERIOD_EXTRA - 7'h01;
  assign loop_off = loop_ctrl_reg[`CGB_LC_DISABLE_BIT];
  assign blk_gain = loop_ctrl_reg[`CGB_LC_GAIN_MSB:`CGB_LC_GAIN_LSB];
  // Only the first n accepted pixels of a period enter the sum
  assign take_pix = bl_state_reg == CGB_BL_RUN && clamp_sync_reg &&
    accept && pix_cnt_reg < n_pix;
  // Period closes on strobe end or after n+10 cycles
  assign period_end = bl_state_reg == CGB_BL_RUN &&
    (!clamp_sync_reg || per_cnt_reg == period_last);
  assign do_update = period_end && pix_cnt_reg != 6'h00 && !loop_off;

  // Error versus 64 per accumulated pixel
  assign target_prod = 13'(pix_cnt_reg) * `CGB_BLACK_TARGET;
  assign target_sum = $signed({8'h00, target_prod});
  assign err = target_sum - $signed({1'b0, sum_reg});
  assign err_scaled = 24'(err) <<< blk_gain;
  // K = gain/256; range clear halves it
  assign delta = loop_ctrl_reg[`CGB_LC_RANGE_BIT] ?
    (err_scaled >>> 8) : (err_scaled >>> 9);
  // Two guard bits let saturation see both overflow directions
  assign acc_sum = $signed({2'b00, acc_reg}) + 18'(delta);

  // ***************************************************
  // Accumulator update
  // ***************************************************

  always_comb
  begin
    acc_next = acc_reg;
    // Host write wins over a same-cycle loop update
    if (wr_black_hi)
      acc_next = {reg_wdata, black_lo_reg, 7'h00};
    else if (do_update)
    begin
      if (acc_sum < 0)
        acc_next = 16'h0000;
      else if (acc_sum > 18'sh0ffff)
        acc_next = 16'hffff;
      else
        acc_next = acc_sum[15:0];
    end
  end

  // ***************************************************
  // Loop state
  // ***************************************************

  always_comb
  begin
    bl_state_next = bl_state_reg;
    case (bl_state_reg)
      CGB_BL_IDLE:
        if (clamp_sync_reg)
          bl_state_next = CGB_BL_RUN;
      CGB_BL_RUN:
        if (!clamp_sync_reg)
          bl_state_next = CGB_BL_IDLE;
      default:
        bl_state_next = CGB_BL_IDLE;
    endcase
  end

  // ***************************************************
  // Loop registers
  // ***************************************************

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg <= `CGB_RST_ACC;
      bl_state_reg <= CGB_BL_IDLE;
      per_cnt_reg <= 7'h00;
      pix_cnt_reg <= 6'h00;
      sum_reg <= 20'h00000;
    end
    else if (clk_en)
    begin
      acc_reg <= acc_next;
      bl_state_reg <= bl_state_next;
      if (bl_state_reg != CGB_BL_RUN || period_end)
      begin
        per_cnt_reg <= 7'h00;
        pix_cnt_reg <= 6'h00;
        sum_reg <= 20'h00000;
      end
      else
      begin
        per_cnt_reg <= per_cnt_reg + 7'h01;
        if (take_pix)
        begin
          pix_cnt_reg <= pix_cnt_reg + 6'h01;
          sum_reg <= sum_reg + 20'(adj_pix);
        end
      end
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************

  // Analog clamp DAC follows the top nine accumulator bits
  assign black_level = acc_reg[15:7];

endmodule : cgb_gain_black

//--- inc/cgb_defines.svh
`ifndef CGB_DEFINES_SVH
`define CGB_DEFINES_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define CGB_ADDR_FULL_SCALE 7'h05
`define CGB_ADDR_LOOP_CTRL 7'h06
`define CGB_ADDR_BLACK_HI 7'h0a
`define CGB_ADDR_BLACK_LO 7'h0b
`define CGB_ADDR_PIX_COUNT 7'h0d
`define CGB_ADDR_OFFSET_A 7'h0e
`define CGB_ADDR_OFFSET_B 7'h0f
`define CGB_ADDR_OFFSET_C 7'h10
`define CGB_ADDR_FORCED_GAIN 7'h14

// ***************************************************
// Field positions
// ***************************************************
`define CGB_FS_CAL_BIT 0
`define CGB_FS_CODE_LSB 1
`define CGB_FS_CODE_MSB 3
`define CGB_LC_RANGE_BIT 0
`define CGB_LC_GAIN_LSB 1
`define CGB_LC_GAIN_MSB 2
`define CGB_LC_DISABLE_BIT 3
`define CGB_PC_N_MSB 5
`define CGB_FG_CODE_MSB 1
`define CGB_FG_EN_BIT 2
`define CGB_BL_LO_ACC_BIT 0
`define CGB_BL_LO_RUN_BIT 1

// ***************************************************
// Reset values and constants
// ***************************************************
`define CGB_RST_FULL_SCALE 8'h0e
`define CGB_RST_LOOP_CTRL 8'h01
`define CGB_RST_PIX_COUNT 8'h10
`define CGB_RST_OFFSET 8'h00
`define CGB_RST_FORCED_GAIN 8'h00
`define CGB_RST_ACC 16'h8000
`define CGB_BLACK_TARGET 13'h0040
`define CGB_PERIOD_EXTRA 7'h0a
`define CGB_PIX_MAX 13'h1fff
`define CGB_FIFO_DEPTH 16

`endif

//--- inc/cgb_pkg.sv
package cgb_pkg;

  typedef enum logic [1:0] {
    CGB_GAIN_1X = 2'b00,
    CGB_GAIN_2X = 2'b01,
    CGB_GAIN_4X = 2'b10,
    CGB_GAIN_8X = 2'b11
  } cgb_gain_t;

  typedef enum logic [0:0] {
    CGB_BL_IDLE = 1'b0,
    CGB_BL_RUN = 1'b1
  } cgb_bl_state_t;

  typedef logic [12:0] cgb_pix_t;

endpackage : cgb_pkg

//--- verif/cgb_ccd_model.sv
`timescale 1ns/1ps
// ****************************************
// Imager and sampling front end
// ****************************************
module cgb_ccd_model (
  input logic clock,
  input logic conv_ready,
  output cgb_pkg::cgb_gain_t gain_code,
  output logic [9:0] conv_data,
  output logic conv_valid,
  output logic clamp_pin
);
  import cgb_pkg::*;
  initial
  begin
    gain_code = CGB_GAIN_1X;
    conv_data = 10'h000;
    conv_valid = 1'b0;
    clamp_pin = 1'b0;
  end
  // Offer held until taken or the limit runs out
  task automatic pixel(input int g, d, lim, output bit ok);
    logic rdy;
    gain_code = cgb_gain_t'(g[1:0]);
    conv_data = d[9:0];
    conv_valid = 1'b1;
    ok = 1'b0;
    repeat (lim)
    begin
      rdy = conv_ready;
      @(posedge clock);
      #1;
      if (rdy)
      begin
        ok = 1'b1;
        break;
      end
    end
  endtask : pixel
  // Released data must not look valid
  task automatic idle();
    conv_valid = 1'b0;
    conv_data = ~conv_data;
  endtask : idle
  task automatic strobe(input int len);
    clamp_pin = 1'b1;
    repeat (len) @(posedge clock);
    #1 clamp_pin = 1'b0;
  endtask : strobe
endmodule : cgb_ccd_model

//--- verif/cgb_gain_black_assertions.sv
`timescale 1ns/1ps
// ****************************************
// Port checks for the gain and black block
// ****************************************
module cgb_gain_black_assertions (
  input logic clock,
  input logic rst_n,
  input logic clk_en,
  input logic clamp_pin,
  input logic reg_wr_en,
  input logic reg_rd_en,
  input logic [6:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input cgb_pkg::cgb_pix_t pix_out,
  input logic pix_out_valid,
  input logic pix_out_ready,
  input logic [8:0] black_level,
  input logic [2:0] full_scale_code,
  input logic cal_start
);
  import cgb_pkg::*;
  logic [3:0] quiet_reg;
  wire wr = reg_wr_en && clk_en;
  wire rd = reg_rd_en && clk_en;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Loop updates trail the strobe through the synchroniser
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      quiet_reg <= 4'h0;
    else if (clamp_pin)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf)
      quiet_reg <= quiet_reg + 4'h1;
  end
  property p_cal;
    wr && reg_addr == 7'h05 && reg_wdata[0] |=> cal_start;
  endproperty
  a_cal: assert property (p_cal) else $error("no cal pulse");
  property p_cal_only;
    cal_start |-> $past(wr && reg_addr == 7'h05 && reg_wdata[0]);
  endproperty
  a_cal_only: assert property (p_cal_only) else $error("stray cal");
  property p_fs;
    wr && reg_addr == 7'h05 |=> full_scale_code == $past(reg_wdata[3:1]);
  endproperty
  a_fs: assert property (p_fs) else $error("full scale");
  property p_bl_wr;
    wr && reg_addr == 7'h0a |=> black_level[8:1] == $past(reg_wdata);
  endproperty
  a_bl_wr: assert property (p_bl_wr) else $error("level write");
  property p_bl_quiet;
    quiet_reg > 4'h8 && !$past(wr) |-> $stable(black_level);
  endproperty
  a_bl_quiet: assert property (p_bl_quiet) else $error("drift");
  property p_bl_rd;
    rd && reg_addr == 7'h0a |=> reg_rdata == $past(black_level[8:1]);
  endproperty
  a_bl_rd: assert property (p_bl_rd) else $error("level read");
  property p_ctl;
    wr && reg_addr == 7'h06 ##1 !wr ##1 rd && !wr && reg_addr == 7'h06
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_ctl: assert property (p_ctl) else $error("loop control");
  property p_pix_hold;
    pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out);
  endproperty
  a_pix_hold: assert property (p_pix_hold) else $error("pixel");
  property p_bl_rst;
    $rose(rst_n) |-> black_level == 9'h100;
  endproperty
  a_bl_rst: assert property (p_bl_rst) else $error("mid level");
  c_cal: cover property (cal_start);
  c_stall: cover property (pix_out_valid && !pix_out_ready);
  c_loop: cover property (quiet_reg == 4'h0 && $changed(black_level));
endmodule : cgb_gain_black_assertions

bind cgb_gain_black cgb_gain_black_assertions chk (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .clamp_pin(clamp_pin),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_out(pix_out),
  .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
  .black_level(black_level), .full_scale_code(full_scale_code),
  .cal_start(cal_start));

//--- verif/test_ccd_gain_adjust_black_level.sv
`timescale 1ns/1ps
// ****************************************
// Self-checking bench
// ****************************************
module test_ccd_gain_adjust_black_level;
  import cgb_pkg::*;
  logic clock, rst_n, clk_en, conv_valid, conv_ready, clamp_pin, cal_start;
  logic reg_wr_en, reg_rd_en, pix_out_valid, pix_out_ready;
  logic [9:0] conv_data;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [8:0] black_level;
  logic [2:0] full_scale_code;
  cgb_gain_t gain_code;
  cgb_pix_t pix_out;
  int bad_count, tests_run, sink, fg, acc, offs[4];
  bit took;
  logic [12:0] exp_q[$];
  cgb_gain_black uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .gain_code(gain_code), .conv_data(conv_data), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .clamp_pin(clamp_pin), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pix_out(pix_out), .pix_out_valid(pix_out_valid),
    .pix_out_ready(pix_out_ready), .black_level(black_level),
    .full_scale_code(full_scale_code), .cal_start(cal_start));
  cgb_ccd_model src (.clock(clock), .conv_ready(conv_ready),
    .gain_code(gain_code), .conv_data(conv_data), .conv_valid(conv_valid),
    .clamp_pin(clamp_pin));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic stop();
    bad_count++;
    $display("ERROR %0t wait timed out", $time);
    print_verdict();
  endtask : stop
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clock);
    #1 reg_wr_en = 1'b0;
    @(posedge clock);
    #1;
  endtask : wr
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clock);
    #1 reg_rd_en = 1'b0;
    check({8'h00, reg_rdata}, {8'h00, e});
    @(posedge clock);
    #1;
  endtask : rchk
  function automatic logic [12:0] pexp(int g, int d);
    int v;
    if (fg >= 0) g = fg;
    v = ((d * 8) >> g) + offs[g];
    return v < 0 ? 13'h0000 : v > 8191 ? 13'h1fff : v[12:0];
  endfunction : pexp
  task automatic send(input int g, d, lim);
    logic [12:0] e;
    e = pexp(g, d);
    src.pixel(g, d, lim, took);
    if (took) exp_q.push_back(e);
    else if (lim > 8) stop();
  endtask : send
  task automatic drain();
    src.idle();
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clock);
    if (exp_q.size() > 0) stop();
    #1;
  endtask : drain
  task automatic line(input int len, d, sh, en);
    int p;
    fork
      src.strobe(len);
      for (int i = 0; i < len + 10; i++) send(0, d, 200);
    join
    src.idle();
    repeat (20) @(posedge clock);
    #1;
    // Strobe seen for len-1 cycles, cut into periods of n+10 = 73
    for (int c = len - 1; c > 0 && en != 0; c -= 73)
    begin
      p = c < 63 ? c : 63;
      acc += ((64 * p - 8 * d * p) << 3) >>> sh;
      acc = acc > 65535 ? 65535 : acc < 0 ? 0 : acc;
    end
    check({7'h00, black_level}, acc >> 7);
  endtask : line
  always @(posedge clock) #1 pix_out_ready = sink == 0 ||
    (sink == 1 && $urandom_range(0, 1) == 1);
  always @(negedge clock)
    if (rst_n && pix_out_valid && pix_out_ready)
      check({3'b000, pix_out},
        exp_q.size() ? exp_q.pop_front() : 16'hffff);
  initial
  begin
    logic [6:0] ra[7];
    logic [7:0] rv[7];
    int v, k;
    ra = '{7'h05, 7'h06, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h14};
    rv = '{8'h0e, 8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    v = $urandom(32'hf2c979c0);
    {rst_n, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
    clk_en = 1'b1;
    pix_out_ready = 1'b0;
    {sink, bad_count, tests_run, k} = '0;
    fg = -1;
    offs = '{0, 0, 0, 0};
    repeat (12) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    for (int i = 0; i < 7; i++) rchk(ra[i], rv[i]);
    rchk(7'h0a, 8'h80);
    rchk(7'h7f, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 7; i++)
    begin
      v = $urandom_range(0, 255);
      wr(ra[i], v[7:0]);
      rchk(ra[i], v[7:0]);
      if (i == 0) check({13'h0, full_scale_code}, {13'h0, v[3:1]});
      if (i > 2 && i < 6) offs[i - 2] = $signed(v[7:0]);
    end
    wr(7'h14, 8'h00);
    wr(7'h05, 8'h0f);
    check({13'h0, full_scale_code}, 16'h0007);
    $display("test register access done");
    sink = 1;
    for (int g = 0; g < 8; g++) send(g % 4, g < 4 ? 0 : 1023, 200);
    for (int i = 0; i < 40; i++) send($urandom_range(0, 3),
      $urandom_range(0, 1023), 200);
    drain();
    sink = 2;
    took = 1'b1;
    while (took && k < 20)
    begin
      send(0, k, 4);
      if (took) k++;
    end
    check(k[15:0], 16'd17);
    sink = 1;
    drain();
    for (int i = 3; i < 6; i++) wr(ra[i], 8'h00);
    offs = '{0, 0, 0, 0};
    for (fg = 0; fg < 4; fg++)
    begin
      wr(7'h14, {6'h01, fg[1:0]});
      for (int i = 0; i < 6; i++) send($urandom_range(0, 3),
        $urandom_range(0, 1023), 200);
      drain();
    end
    fg = -1;
    wr(7'h14, 8'h00);
    $display("test pixel path done");
    sink = 0;
    wr(7'h0d, 8'd63);
    wr(7'h06, 8'h07);
    wr(7'h0b, 8'h00);
    wr(7'h0a, 8'h80);
    acc = 32768;
    repeat (4) line(70, 0, 8, 1);
    wr(7'h06, 8'h06);
    repeat (2) line(70, 0, 9, 1);
    repeat (2) line(70, 8, 9, 1);
    wr(7'h06, 8'h0f);
    line(70, 0, 8, 0);
    wr(7'h06, 8'h07);
    wr(7'h0b, 8'h01);
    wr(7'h0a, 8'hff);
    acc = 65408;
    rchk(7'h0a, 8'hff);
    repeat (2) line(70, 0, 8, 1);
    wr(7'h0b, 8'h00);
    wr(7'h0a, 8'h80);
    acc = 32768;
    line(150, 0, 8, 1);
    $display("test black loop done");
    print_verdict();
  end
endmodule : test_ccd_gain_adjust_black_level
